//--- axsbm_pkg.sv
/*
  constants shared by the auxiliary sensor bus master: clock rates, bus timing,
  sensor burst layout and the primary-bus slave address.
  assumes nothing; imported by the result memory, top, monitor and testbench files.
*/
package axsbm_pkg;
	// system clock and link (aux engine) clock
	localparam int SYS_CLK_HZ      = 25_000_000;            // main clock rate
	localparam int LINK_CLK_PS     = 15_000;                // aux engine clock period
	// auxiliary bus bit rate
	localparam int AUX_SCL_KHZ     = 400;                   // fast-mode ceiling
	localparam int AUX_BIT_PS      = 1_000_000_000 / AUX_SCL_KHZ;
	// quarter bit, rounded up so the bus never runs faster than allowed
	localparam int AUX_QTR_CYCLES  = (AUX_BIT_PS / 4 + LINK_CLK_PS - 1) / LINK_CLK_PS;
	// sync clock output
	localparam int SYNC_CLK_HZ     = 1_000_000;             // 1 MHz reference
	localparam int SYNC_DIV        = SYS_CLK_HZ / SYNC_CLK_HZ;
	localparam int SYNC_HIGH       = SYNC_DIV / 2;
	// accelerometer burst: x, y, z of two bytes each
	localparam int AXIS_BYTES      = 2;
	localparam int AXIS_COUNT      = 3;
	localparam int ACCEL_BYTES     = AXIS_BYTES * AXIS_COUNT;
	localparam logic [7:0] ACCEL_BASE = 8'h00;              // first byte slot of accel data
	localparam logic [7:0] SECOND_BASE = 8'h06;             // first byte slot of second sensor
	// primary-bus slave address, upper six bits
	localparam logic [5:0] SLAVE_ADDR_HI = 6'h34;
	// engine states
	typedef enum logic [2:0] {
		AXSBM_IDLE   = 3'b000,
		AXSBM_START  = 3'b001,
		AXSBM_TX     = 3'b010,
		AXSBM_RSTART = 3'b011,
		AXSBM_RX     = 3'b100,
		AXSBM_STOP   = 3'b101
	} axsbm_state_t;
endpackage

//--- axsbm_result_if.sv
/*
  carrier between the aux engine and the result memory: a write side on the
  link clock and a read side on the system clock.
  assumes the writer never writes while the reader uses the data.
*/
`timescale 1ns/1ps
interface axsbm_result_if #(parameter int AW = 4, parameter int DW = 8);
	logic          we;     // write strobe, link domain
	logic [AW-1:0] waddr;  // write slot
	logic [DW-1:0] wdata;  // received byte
	logic [AW-1:0] raddr;  // read slot, system domain
	logic [DW-1:0] rdata;  // registered read data
	modport writer (output we, output waddr, output wdata);
	modport reader (output raddr, input rdata);
	modport mem    (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

//--- axsbm_result_mem.sv
/*
  small two-clock result memory holding the bytes of the latest sensor burst.
  assumes writes and reads are kept apart by the engine handshake, so no word
  is read while it is being written.
*/
`timescale 1ns/1ps
module axsbm_result_mem #(
	parameter int AW = 4,
	parameter int DW = 8
) (
	input  wire logic wclk,
	input  wire logic rclk,
	axsbm_result_if.mem port
);
	import axsbm_pkg::*;
	logic [DW-1:0] store [0:(1<<AW)-1]; // byte slots, no reset needed

	// write side on link clock
	always_ff @(posedge wclk) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	// read data out of a register
	always_ff @(posedge rclk) begin
		port.rdata <= store[port.raddr];
	end
endmodule // axsbm_result_mem

//--- axsbm_top.sv
/*
  auxiliary sensor bus master with pass-through for a gyroscope device.
  holds mode control, sync clock, slave address and the aux bus engine.
  assumes config inputs come from logic on clk and stay put while busy; aux
  pins and the address pin arrive from outside; link_clk runs free.
*/
// Summary of operation
// - one aux mode at a time: master or pass-through
// - device masters aux bus transactions itself
// - accel burst read: x, y, z, two bytes each
// - optional second sensor read in same burst
// - pass-through stops the aux engine
// - pass-through closes switches joining aux to primary
// - primary bus: always slave, never master
// - slave address lsb from address pin
// - drive 1 MHz sync clock out
// - selectable aux level: main or io supply
// - aux nack raises status and event
`timescale 1ns/1ps
module axsbm_top #(
	parameter int AW     = 4,
	parameter int QTR    = axsbm_pkg::AUX_QTR_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       link_clk,
	input  wire logic       pass_request,
	input  wire logic       master_enable,
	input  wire logic       sample_tick,
	input  wire logic [6:0] accel_dev_addr,
	input  wire logic [7:0] accel_reg,
	input  wire logic       second_enable,
	input  wire logic [6:0] second_dev_addr,
	input  wire logic [7:0] second_reg,
	input  wire logic [3:0] second_len,
	input  wire logic       aux_level_io_sel,
	input  wire logic       addr_lsb_select_pin,
	input  wire logic       nack_clear,
	input  wire logic [AW-1:0] result_addr,
	output logic [7:0]      result_data,
	output logic            result_ready,
	output logic            aux_busy,
	output logic            aux_nack_status,
	output logic            aux_nack_event,
	output logic            pass_switch_closed,
	output logic            logic_io_supply_level,
	output logic [6:0]      slave_address,
	output logic            sync_clock_out,
	input  wire logic       aux_serial_clock_in,
	output logic            aux_serial_clock_out,
	output logic            aux_serial_clock_oe,
	input  wire logic       aux_serial_data_in,
	output logic            aux_serial_data_out,
	output logic            aux_serial_data_oe
);
	import axsbm_pkg::*;

	axsbm_result_if #(.AW(AW), .DW(8)) res ();  // engine to memory
	axsbm_result_mem #(.AW(AW), .DW(8)) u_mem (.wclk(link_clk), .rclk(clk), .port(res));

	// ---------------- system clock domain ----------------
	logic       ad_s1, ad_s2;        // address pin synchroniser
	logic       req_tgl;             // new burst request toggle
	logic       done_s1, done_s2, done_s3; // burst done toggle sync
	logic       nack_s1, nack_s2, nack_s3; // nack toggle sync
	logic [7:0] sync_cnt;            // sync clock divider
	logic       done_tgl, nack_tgl;  // link domain toggles
	logic [6:0] cfg_addr0, cfg_addr1; // latched device addresses
	logic [7:0] cfg_reg0, cfg_reg1;   // latched start registers
	logic [3:0] cfg_len1;             // second sensor byte count
	logic       cfg_en1;              // second sensor on

	assign res.raddr   = result_addr;
	assign result_data = res.rdata;
	assign aux_busy    = req_tgl ^ done_s2;
	assign aux_serial_clock_out = 1'b0; // open drain: only ever pulls low
	assign aux_serial_data_out  = 1'b0;

	// address pin through two flops, then lsb of our slave address
	always_ff @(posedge clk) begin
		if (rst) begin
			ad_s1 <= 1'b0;
			ad_s2 <= 1'b0;
			slave_address <= 7'h00;
		end else begin
			ad_s1 <= addr_lsb_select_pin;
			ad_s2 <= ad_s1;
			slave_address <= {SLAVE_ADDR_HI, ad_s2};
		end
	end

	// mode switch only while engine idle, so no aux cycle is cut
	always_ff @(posedge clk) begin
		if (rst) begin
			pass_switch_closed <= 1'b0;
		end else if (!aux_busy) begin
			pass_switch_closed <= pass_request;
		end
	end

	// burst request, never while pass-through is in or pending
	always_ff @(posedge clk) begin
		if (rst) begin
			req_tgl   <= 1'b0;
			cfg_addr0 <= 7'h00;
			cfg_addr1 <= 7'h00;
			cfg_reg0  <= 8'h00;
			cfg_reg1  <= 8'h00;
			cfg_len1  <= 4'h0;
			cfg_en1   <= 1'b0;
		end else if (sample_tick && master_enable && !pass_request && !pass_switch_closed && !aux_busy) begin
			req_tgl   <= ~req_tgl;
			cfg_addr0 <= accel_dev_addr;
			cfg_reg0  <= accel_reg;
			cfg_addr1 <= second_dev_addr;
			cfg_reg1  <= second_reg;
			cfg_len1  <= second_len;
			cfg_en1   <= second_enable && (second_len != 4'h0);
		end
	end

	// done and nack toggles back from link domain
	always_ff @(posedge clk) begin
		if (rst) begin
			{done_s1, done_s2, done_s3} <= 3'b000;
			{nack_s1, nack_s2, nack_s3} <= 3'b000;
			result_ready   <= 1'b0;
			aux_nack_event <= 1'b0;
		end else begin
			done_s1 <= done_tgl;
			done_s2 <= done_s1;
			done_s3 <= done_s2;
			nack_s1 <= nack_tgl;
			nack_s2 <= nack_s1;
			nack_s3 <= nack_s2;
			result_ready   <= done_s2 ^ done_s3;
			aux_nack_event <= nack_s2 ^ nack_s3;
		end
	end

	// sticky nack status; a new nack beats a clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			aux_nack_status <= 1'b0;
		end else if (nack_s2 ^ nack_s3) begin
			aux_nack_status <= 1'b1;
		end else if (nack_clear) begin
			aux_nack_status <= 1'b0;
		end
	end

	// aux pad supply select, held in a flop
	always_ff @(posedge clk) begin
		if (rst) begin
			logic_io_supply_level <= 1'b0;
		end else begin
			logic_io_supply_level <= aux_level_io_sel;
		end
	end

	// 1 MHz sync clock from 25 MHz: 12 high, 13 low
	always_ff @(posedge clk) begin
		if (rst) begin
			sync_cnt       <= 8'h00;
			sync_clock_out <= 1'b0;
		end else begin
			sync_cnt       <= (sync_cnt == 8'(SYNC_DIV - 1)) ? 8'h00 : sync_cnt + 8'h01;
			sync_clock_out <= (sync_cnt < 8'(SYNC_HIGH));
		end
	end

	// ---------------- link clock domain ----------------
	logic         lrst_s1, lrst;        // reset brought onto link clock
	logic         req_s1, req_s2, req_seen; // request toggle sync
	logic         scl_s1, scl_s2, sda_s1, sda_s2; // pin synchronisers
	axsbm_state_t st;                   // engine state
	logic [1:0]   q;                    // quarter of current symbol
	logic [7:0]   qcnt;                 // cycles within a quarter
	logic [3:0]   bitn;                 // bit within byte plus ack
	logic [8:0]   shift;                // transmit byte plus released ack
	logic [7:0]   rx;                   // receive shifter
	logic [1:0]   phase;                // 0 dev write, 1 reg, 2 dev read
	logic         seg;                  // 0 accelerometer, 1 second sensor
	logic         ack_bad;              // sampled ack was high
	logic [3:0]   left;                 // bytes left to read
	logic [AW-1:0] slot;                // next memory slot
	logic         scl_lvl, sda_lvl;     // wanted line levels
	wire          qend   = (qcnt == 8'(QTR - 1));
	wire          samp   = qend && (q == 2'd2);
	wire          symend = qend && (q == 2'd3);
	wire [6:0]    dev    = seg ? cfg_addr1 : cfg_addr0;

	// reset and pins through two flops each; scl kept for later stretching
	always_ff @(posedge link_clk) begin
		lrst_s1 <= rst;
		lrst    <= lrst_s1;
		scl_s1  <= aux_serial_clock_in;
		scl_s2  <= scl_s1;
		sda_s1  <= aux_serial_data_in;
		sda_s2  <= sda_s1;
		req_s1  <= req_tgl;
		req_s2  <= req_s1;
	end

	// wanted levels per state and quarter
	always_comb begin
		scl_lvl = 1'b1;
		sda_lvl = 1'b1;
		unique case (st)
			AXSBM_IDLE: begin
				scl_lvl = 1'b1;
				sda_lvl = 1'b1;
			end
			AXSBM_START, AXSBM_RSTART: begin // high, fall sda, fall scl
				scl_lvl = (q == 2'd1) || (q == 2'd2);
				sda_lvl = (q < 2'd2);
			end
			AXSBM_TX: begin
				scl_lvl = q[1];
				sda_lvl = shift[8];
			end
			AXSBM_RX: begin // ack all but the last byte
				scl_lvl = q[1];
				sda_lvl = (bitn == 4'd8) ? (left == 4'h1) : 1'b1;
			end
			AXSBM_STOP: begin
				scl_lvl = (q != 2'd0);
				sda_lvl = q[1];
			end
			default: begin
				scl_lvl = 1'b1;
				sda_lvl = 1'b1;
			end
		endcase
	end

	// open-drain pads: enable means pull low
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			aux_serial_clock_oe <= 1'b0;
			aux_serial_data_oe  <= 1'b0;
		end else begin
			aux_serial_clock_oe <= ~scl_lvl;
			aux_serial_data_oe  <= ~sda_lvl;
		end
	end

	// quarter timing, stopped in idle
	always_ff @(posedge link_clk) begin
		if (lrst || st == AXSBM_IDLE) begin
			qcnt <= 8'h00;
			q    <= 2'd0;
		end else begin
			qcnt <= qend ? 8'h00 : qcnt + 8'h01;
			q    <= qend ? q + 2'd1 : q;
		end
	end

	// receive shifter and ack check, taken at the middle of scl high
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			rx      <= 8'h00;
			ack_bad <= 1'b0;
		end else if (samp) begin
			if (st == AXSBM_RX && bitn < 4'd8) begin
				rx <= {rx[6:0], sda_s2};
			end
			if (st == AXSBM_TX && bitn == 4'd8) begin
				ack_bad <= sda_s2;
			end
		end
	end

	// burst sequencer
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			st <= AXSBM_IDLE;
			req_seen <= 1'b0;
			done_tgl <= 1'b0;
			nack_tgl <= 1'b0;
			bitn <= 4'h0;
			shift <= 9'h1ff;
			phase <= 2'd0;
			seg <= 1'b0;
			left <= 4'h0;
			slot <= '0;
			res.we <= 1'b0; // no stray write while held in reset
		end else begin
			res.we <= 1'b0;
			unique case (st)
				AXSBM_IDLE: begin
					if (req_s2 != req_seen) begin
						req_seen <= req_s2;
						seg  <= 1'b0;
						slot <= AW'(ACCEL_BASE);
						st   <= AXSBM_START;
					end
				end
				AXSBM_START, AXSBM_RSTART: begin
					if (symend) begin
						bitn  <= 4'h0;
						shift <= {dev, (st == AXSBM_RSTART), 1'b1};
						phase <= (st == AXSBM_RSTART) ? 2'd2 : 2'd0;
						st    <= AXSBM_TX;
					end
				end
				AXSBM_TX: begin
					if (symend) begin
						shift <= {shift[7:0], 1'b1};
						bitn  <= bitn + 4'h1;
						if (bitn == 4'd8) begin
							bitn <= 4'h0;
							if (ack_bad) begin
								nack_tgl <= ~nack_tgl;
								st <= AXSBM_STOP;
							end else if (phase == 2'd0) begin
								shift <= {(seg ? cfg_reg1 : cfg_reg0), 1'b1};
								phase <= 2'd1;
							end else if (phase == 2'd1) begin
								st <= AXSBM_RSTART;
							end else begin
								left <= seg ? cfg_len1 : 4'(ACCEL_BYTES);
								st   <= AXSBM_RX;
							end
						end
					end
				end
				AXSBM_RX: begin
					if (symend) begin
						bitn <= bitn + 4'h1;
						if (bitn == 4'd8) begin // byte and ack done
							res.we    <= 1'b1;
							res.waddr <= slot;
							res.wdata <= rx;
							slot <= slot + AW'(1);
							left <= left - 4'h1;
							bitn <= 4'h0;
							if (left == 4'h1) begin
								st <= AXSBM_STOP;
							end
						end
					end
				end
				AXSBM_STOP: begin
					if (symend) begin
						if (!seg && cfg_en1 && !ack_bad) begin
							seg  <= 1'b1;
							slot <= AW'(SECOND_BASE);
							st   <= AXSBM_START;
						end else begin
							done_tgl <= ~done_tgl;
							st <= AXSBM_IDLE;
						end
					end
				end
				default: st <= AXSBM_IDLE;
			endcase
		end
	end
endmodule // axsbm_top

//--- axsbm_monitor.sv
/*
  checker on the ports of the aux sensor bus master top.
  assumes rst is synchronous on clk; bound to every top instance below.
*/
`timescale 1ns/1ps
module axsbm_monitor
	import axsbm_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       sample_tick,
	input wire logic       master_enable,
	input wire logic       pass_request,
	input wire logic       aux_busy,
	input wire logic       pass_switch_closed,
	input wire logic       aux_nack_event,
	input wire logic       aux_nack_status,
	input wire logic       aux_level_io_sel,
	input wire logic       logic_io_supply_level,
	input wire logic       addr_lsb_select_pin,
	input wire logic [6:0] slave_address,
	input wire logic       sync_clock_out,
	input wire logic       aux_serial_clock_oe,
	input wire logic       aux_serial_data_oe
);
	logic       last_sync; // sync level one clk back
	logic [4:0] run;       // cycles spent in the level just left
	logic       seen;      // first level after reset may be partial
	// run length of each sync clock level
	always_ff @(posedge clk) begin
		if (rst) begin
			last_sync <= 1'b0;
			run       <= 5'h00;
			seen      <= 1'b0;
		end else begin
			last_sync <= sync_clock_out;
			seen      <= seen | (sync_clock_out != last_sync);
			run       <= (sync_clock_out != last_sync) ? 5'h01 : run + 5'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_sync_high_len: assert property (seen && last_sync && !sync_clock_out |-> run == 5'h0c)
		else $error("sync clock high phase length wrong");
	a_sync_low_len: assert property (seen && !last_sync && sync_clock_out |-> run == 5'h0d)
		else $error("sync clock low phase length wrong");
	a_addr_upper: assert property (!$past(rst) |-> slave_address[6:1] == SLAVE_ADDR_HI)
		else $error("slave address upper bits wrong");
	a_addr_pin: assert property ($stable(addr_lsb_select_pin) [*5] |-> slave_address[0] == addr_lsb_select_pin)
		else $error("slave address lsb ignores the pin");
	a_io_copy: assert property (!$past(rst) |-> logic_io_supply_level == $past(aux_level_io_sel))
		else $error("aux level select not followed");
	a_take_burst: assert property (sample_tick && master_enable && !pass_request && !pass_switch_closed && !aux_busy
		|=> aux_busy)
		else $error("burst request not taken");
	a_one_mode: assert property (aux_busy |-> !pass_switch_closed)
		else $error("switch closed during a burst");
	a_switch_follow: assert property (!aux_busy |=> pass_switch_closed == $past(pass_request))
		else $error("switch does not follow pass request");
	a_switch_wait: assert property (aux_busy |=> $stable(pass_switch_closed))
		else $error("switch moved while burst outstanding");
	a_quiet_pass: assert property (pass_switch_closed |-> !aux_serial_clock_oe && !aux_serial_data_oe)
		else $error("aux engine drives while joined");
	a_nack_sticky: assert property (aux_nack_event |-> ##[0:1] aux_nack_status)
		else $error("nack event without status");
	// main scenarios reached
	c_burst: cover property ($fell(aux_busy));
	c_nack: cover property (aux_nack_event);
	c_joined: cover property ($rose(pass_switch_closed));
endmodule // axsbm_monitor

bind axsbm_top axsbm_monitor i_axsbm_monitor (.clk, .rst, .sample_tick, .master_enable, .pass_request, .aux_busy,
	.pass_switch_closed, .aux_nack_event, .aux_nack_status, .aux_level_io_sel, .logic_io_supply_level,
	.addr_lsb_select_pin, .slave_address, .sync_clock_out, .aux_serial_clock_oe, .aux_serial_data_oe);

//--- axsbm_sensor_model.sv
/*
  behavioural sensor on the aux wires: acks its address, takes a register
  pointer, returns (pointer ^ KEY) bytes on reads.
  assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
module axsbm_sensor_model #(
	parameter logic [6:0] DEV = 7'h1d, // bus address
	parameter logic [7:0] KEY = 8'h5a  // data pattern mask
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic refuse,
	output logic      sda_oe
);
	logic [7:0] sh, ptr, d;           // shift, pointer, outgoing byte
	logic       act, first, match, rd, rd_pend;
	int         bitn;                 // bit slot within a byte
	initial begin
		sda_oe = 1'b0;
		act = 1'b0;
	end
	// start and stop; the delay skips sda moves made as scl falls
	always @(sda) begin
		#1;
		if (scl && !sda) begin
			act = 1'b1;
			first = 1'b1;
			rd = 1'b0;
			rd_pend = 1'b0;
			bitn = 0;
		end else if (scl && sda) begin
			act = 1'b0;
			sda_oe = 1'b0;
		end
	end
	// sample on the rising clock; master nack ends the read
	always @(posedge scl) begin
		if (act && bitn < 8) sh = {sh[6:0], sda};
		else if (act && rd && sda) rd = 1'b0;
		bitn = bitn + 1;
	end
	// drive ack or data after the falling clock, never stretch
	always @(negedge scl) begin
		if (act) begin
			sda_oe = 1'b0;
			if (bitn == 8 && !rd) begin
				if (first) begin
					match = (sh[7:1] == DEV) && !refuse;
					rd_pend = match && sh[0];
					first = 1'b0;
				end else if (match) begin
					ptr = sh;
				end
				sda_oe = match;
			end else if (bitn == 9) begin
				if (rd) ptr = ptr + 8'h01;
				rd = rd | rd_pend;
				rd_pend = 1'b0;
				bitn = 0;
			end
			d = (ptr ^ KEY) << bitn;
			if (rd && bitn < 8) sda_oe = !d[7];
		end
	end
endmodule // axsbm_sensor_model

//--- axsbm_top_tb.sv
/*
  testbench for the aux sensor bus master with two sensor models on the wires.
  assumes the monitor binds itself; both aux wires have pull-ups.
*/
`timescale 1ns/1ps
module axsbm_top_tb;
	import axsbm_pkg::*;
	logic       clk, rst, link_clk, pass_request, master_enable, sample_tick, second_enable;
	logic       aux_level_io_sel, addr_lsb_select_pin, nack_clear, refuse, nack_seen, refuse2, early_join, host_ack;
	logic       scl_out, sda_out, host_scl_oe, host_sda_oe; // pad data and host pulls across the switches
	logic [6:0] accel_dev_addr, second_dev_addr, slave_address;
	logic [7:0] accel_reg, second_reg, result_data;
	logic [3:0] second_len, result_addr;
	logic       result_ready, aux_busy, aux_nack_status, aux_nack_event, pass_switch_closed;
	logic       logic_io_supply_level, sync_clock_out, aux_serial_clock_oe, aux_serial_data_oe, m1_oe, m2_oe;
	int         n_fail, n_checks, n;
	// pull-ups unless pulled; host reaches the wires only through the closed switches
	wire logic  scl_w = (aux_serial_clock_oe ? scl_out : 1'b1) && !(host_scl_oe && pass_switch_closed);
	wire logic  sda_w = (aux_serial_data_oe ? sda_out : 1'b1) && !(m1_oe || m2_oe || (host_sda_oe && pass_switch_closed));
	axsbm_top #(.QTR(2)) i_axsbm_top (.clk, .rst, .link_clk, .pass_request, .master_enable, .sample_tick,
		.accel_dev_addr, .accel_reg, .second_enable, .second_dev_addr, .second_reg, .second_len,
		.aux_level_io_sel, .addr_lsb_select_pin, .nack_clear, .result_addr, .result_data, .result_ready,
		.aux_busy, .aux_nack_status, .aux_nack_event, .pass_switch_closed, .logic_io_supply_level,
		.slave_address, .sync_clock_out, .aux_serial_clock_in(scl_w), .aux_serial_clock_out(scl_out),
		.aux_serial_clock_oe, .aux_serial_data_in(sda_w), .aux_serial_data_out(sda_out), .aux_serial_data_oe);
	axsbm_sensor_model #(.DEV(7'h1d), .KEY(8'h5a)) i_axsbm_sensor_model (.scl(scl_w), .sda(sda_w),
		.refuse(refuse), .sda_oe(m1_oe));
	axsbm_sensor_model #(.DEV(7'h1e), .KEY(8'ha5)) i_axsbm_sensor_model_2nd (.scl(scl_w), .sda(sda_w),
		.refuse(refuse2), .sda_oe(m2_oe));
	always #20 clk = ~clk;
	// link clock offset so its edges never line up with clk
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wait_ready();
		for (int k = 0; result_ready !== 1'b1; k++) begin
			@(negedge clk);
			if (aux_nack_event === 1'b1) nack_seen = 1'b1;
			if (aux_busy === 1'b1 && pass_switch_closed !== 1'b0) early_join = 1'b1;
			if (k > 5000) chk("result_ready", 8'h01, 8'h00);
			if (k > 5000) report_and_stop();
		end
	endtask
	task automatic burst(input logic exp_busy, input logic go_pass);
		@(negedge clk);
		sample_tick = 1'b1;
		@(negedge clk);
		sample_tick = 1'b0;
		pass_request = go_pass;
		nack_seen = 1'b0;
		early_join = 1'b0;
		chk("aux_busy", {7'h00, exp_busy}, {7'h00, aux_busy});
		if (exp_busy) wait_ready();
	endtask
	task automatic rd_slot(input logic [3:0] a, input logic [7:0] e);
		result_addr = a;
		@(negedge clk);
		chk("result_data", e, result_data);
	endtask
	task automatic run_len(input logic lvl, output int cnt);
		cnt = 0;
		for (int k = 0; k < 60 && sync_clock_out !== lvl; k++) @(negedge clk);
		while (sync_clock_out === lvl && cnt < 60) begin
			@(negedge clk);
			cnt++;
		end
		if (cnt >= 60) begin // stuck sync clock counts as a failure
			n_fail++;
			report_and_stop();
		end
	endtask
	// host masters the sensor across the closed switches: start, one byte, ack, stop
	task automatic host_xfer(input logic [7:0] b, output logic ack);
		@(negedge clk);
		host_sda_oe = 1'b1; // start: sda falls while scl high
		for (int i = 8; i >= 0; i--) begin
			@(negedge clk);
			host_scl_oe = 1'b1;
			@(negedge clk);
			host_sda_oe = (i > 0) ? !b[i-1] : 1'b0; // ninth slot released for the ack
			@(negedge clk);
			host_scl_oe = 1'b0;
			@(negedge clk);
			ack = sda_w;
		end
		@(negedge clk);
		host_scl_oe = 1'b1;
		@(negedge clk);
		host_sda_oe = 1'b1;
		@(negedge clk);
		host_scl_oe = 1'b0;
		@(negedge clk);
		host_sda_oe = 1'b0; // stop: sda rises while scl high
	endtask
	// accel burst, then the same burst with the second sensor appended
	task automatic t_bursts();
		burst(1'b1, 1'b0);
		for (int k = 0; k < ACCEL_BYTES; k++) rd_slot(4'(k), (accel_reg + 8'(k)) ^ 8'h5a);
		chk("nack_status", 8'h00, {7'h00, aux_nack_status});
		second_enable = 1'b1;
		burst(1'b1, 1'b0);
		for (int k = 0; k < 3; k++) rd_slot(SECOND_BASE[3:0] + 4'(k), (second_reg + 8'(k)) ^ 8'ha5);
		rd_slot(4'h5, (accel_reg + 8'h05) ^ 8'h5a);
		$display("test bursts done");
	endtask
	// refused address, then clear of the sticky flag
	task automatic t_nack();
		refuse = 1'b1;
		burst(1'b1, 1'b0);
		refuse = 1'b0;
		chk("nack_event", 8'h01, {7'h00, nack_seen});
		chk("nack_status", 8'h01, {7'h00, aux_nack_status});
		// second sensor refuses: accel part still lands, nack raised again
		refuse2 = 1'b1;
		burst(1'b1, 1'b0);
		refuse2 = 1'b0;
		chk("nack_event", 8'h01, {7'h00, nack_seen});
		rd_slot(4'h0, accel_reg ^ 8'h5a);
		nack_clear = 1'b1;
		@(negedge clk);
		nack_clear = 1'b0;
		@(negedge clk);
		chk("nack_status", 8'h00, {7'h00, aux_nack_status});
		$display("test nack done");
	endtask
	// pass request in mid-burst waits, then joins and blocks bursts
	task automatic t_pass();
		burst(1'b1, 1'b1);
		chk("switch_wait", 8'h00, {7'h00, early_join});
		repeat (2) @(negedge clk);
		chk("switch", 8'h01, {7'h00, pass_switch_closed});
		burst(1'b0, 1'b1);
		chk("scl_oe", 8'h00, {7'h00, aux_serial_clock_oe});
		host_xfer({7'h1d, 1'b0}, host_ack);
		chk("host_ack", 8'h00, {7'h00, host_ack});
		pass_request = 1'b0;
		repeat (2) @(negedge clk);
		chk("switch", 8'h00, {7'h00, pass_switch_closed});
		$display("test pass done");
	endtask
	// level select, address pin and sync clock
	task automatic t_static();
		for (int v = 1; v >= 0; v--) begin
			aux_level_io_sel = 1'(v);
			addr_lsb_select_pin = 1'(v);
			repeat (6) @(negedge clk);
			chk("io_level", 8'(v), {7'h00, logic_io_supply_level});
			chk("slave_address", {1'b0, SLAVE_ADDR_HI, 1'(v)}, {1'b0, slave_address});
		end
		run_len(1'b0, n);
		run_len(1'b1, n);
		chk("sync_high", 8'h0c, n[7:0]);
		run_len(1'b0, n);
		chk("sync_low", 8'h0d, n[7:0]);
		$display("test static done");
	endtask
	initial begin
		{clk, pass_request, sample_tick, second_enable, aux_level_io_sel} = 5'h00;
		{addr_lsb_select_pin, nack_clear, refuse, nack_seen, refuse2, early_join, host_scl_oe, host_sda_oe} = 8'h00;
		{rst, master_enable} = 2'h3;
		{accel_dev_addr, second_dev_addr, accel_reg, second_reg} = {7'h1d, 7'h1e, 8'h28, 8'h03};
		{second_len, result_addr} = {4'h3, 4'h0};
		{n_fail, n_checks} = {32'h0, 32'h0};
		repeat (8) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		t_bursts();
		t_nack();
		t_pass();
		t_static();
		report_and_stop();
	end
endmodule // axsbm_top_tb
